// [test_ubt_core.sv]
// Testbench of the serial bit-timing core
`timescale 1ns/1ns
module test_ubt_core;
  import ubt_pkg::*;
  logic                clk;
  logic                resetn;
  logic                unit_enable;
  logic                baud_prescale_select;
  logic [RELOAD_W-1:0] baud_reload_value;
  logic                tx_request;
  logic [DATA_W-1:0]   tx_data;
  logic                tx_busy_ff;
  logic                serial_tx_pin_ff;
  logic                line_driver_enable_ff;
  logic                serial_rx_pin;
  logic [DATA_W-1:0]   rx_data_ff;
  logic                rx_valid_ff;
  logic                rx_frame_error_ff;
  int                  failures;
  int                  n_compared;
  int                  bitc;
  ubt_core u_ubt_core
  (
    .clk                   (clk),
    .resetn                (resetn),
    .unit_enable           (unit_enable),
    .baud_prescale_select  (baud_prescale_select),
    .baud_reload_value     (baud_reload_value),
    .tx_request            (tx_request),
    .tx_data               (tx_data),
    .tx_busy_ff            (tx_busy_ff),
    .serial_tx_pin_ff      (serial_tx_pin_ff),
    .line_driver_enable_ff (line_driver_enable_ff),
    .serial_rx_pin         (serial_rx_pin),
    .rx_data_ff            (rx_data_ff),
    .rx_valid_ff           (rx_valid_ff),
    .rx_frame_error_ff     (rx_frame_error_ff)
  );
  ubt_remote u_ubt_remote (.clk(clk), .line_in(serial_tx_pin_ff), .line_out(serial_rx_pin));
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic set_rate(input logic ps, input logic [RELOAD_W-1:0] rl);
    unit_enable = 1'h0;
    baud_prescale_select = ps;
    baud_reload_value = rl;
    @(negedge clk);
    unit_enable = 1'h1;
    bitc = OVERSAMPLE * (PRESCALE_BASE + int'(ps)) * (int'(rl) + 1);
  endtask
  task automatic t_tx(input logic [7:0] d);
    logic [9:0] f;
    int         w;
    fork
      u_ubt_remote.collect(bitc, f);
      begin
        tx_data = d;
        tx_request = 1'h1;
        @(negedge clk);
        tx_request = 1'h0;
        w = 0;
        while (tx_busy_ff !== 1'h1 && w <= bitc + 4)
        begin
          @(negedge clk);
          w++;
        end
        check("start delay", 10'h1, 10'(w <= bitc + 4));
        check("driver on", 10'h1, 10'(line_driver_enable_ff));
        tx_data = ~d;
        tx_request = 1'h1;
        @(negedge clk);
        tx_request = 1'h0;
      end
    join
    @(negedge clk);
    check("tx frame", {1'h1, d, 1'h0}, f);
    check("refused and released", 10'h0, {tx_busy_ff, line_driver_enable_ff});
  endtask
  task automatic t_rx(input logic [7:0] d, input logic stop, input int n);
    int w;
    fork
      u_ubt_remote.send(d, stop, n);
      begin
        w = 0;
        while (rx_valid_ff !== 1'h1 && w < 11 * n)
        begin
          @(negedge clk);
          w++;
        end
        check("rx frame", {1'h1, ~stop, d}, {rx_valid_ff, rx_frame_error_ff, rx_data_ff});
        check("rx sample point", 10'h1, 10'(w > 9 * bitc && w < 10 * bitc));
      end
    join
  endtask
  // Short low pulse on the receive line must not yield a byte
  task automatic t_glitch(input int n);
    int seen;
    seen = 0;
    @(negedge clk);
    fork
      begin
        u_ubt_remote.drive(1'h0, n / 4);
        u_ubt_remote.drive(1'h1, 11 * n);
      end
      repeat (11 * n)
      begin
        @(negedge clk);
        if (rx_valid_ff === 1'h1)
          seen++;
      end
    join
    check("glitch ignored", 10'h0, 10'(seen));
  endtask
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #400000;
    failures++;
    conclude;
  end
  initial
  begin
    resetn = 1'h0;
    tx_request = 1'h0;
    tx_data = 8'h00;
    failures = 0;
    n_compared = 0;
    set_rate(1'h0, 13'h0001);
    repeat (4) @(negedge clk);
    resetn = 1'h1;
    t_tx(8'ha5);
    t_tx(8'h3c);
    t_rx(8'h96, 1'h1, bitc);
    t_rx(8'h4b, 1'h1, bitc - 2);
    t_rx(8'hc3, 1'h0, bitc);
    t_glitch(bitc);
    t_rx(8'h81, 1'h1, bitc);
    set_rate(1'h1, 13'h0002);
    t_tx(8'h69);
    t_rx(8'he1, 1'h1, bitc);
    conclude;
  end
endmodule

// [ubt_baud_gen.sv]
// Free-running reload baud generator producing sixteen-times oversample ticks
`timescale 1ns/1ns
module ubt_baud_gen
#(
  parameter int RELOAD_W = 13
)
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                run,
  input  wire logic                baud_prescale_select,
  input  wire logic [RELOAD_W-1:0] baud_reload_value,
  output logic                     tick16
);
  import ubt_pkg::*;

  logic [1:0]          pre_ff;
  logic [RELOAD_W-1:0] cnt_ff;
  logic                pre_wrap;

  // Prescale divides by two or three
  assign pre_wrap = (pre_ff == (baud_prescale_select ? PRE_MAX1 : PRE_MAX0));

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pre_ff <= 2'h0;
    else if (!run || pre_wrap)
      pre_ff <= 2'h0;
    else
      pre_ff <= pre_ff + 2'h1;
  end

  // Reload counter divides by reload plus one; state stays internal
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= '0;
      tick16 <= 1'b0;
    end
    else
    begin
      tick16 <= 1'b0;
      if (!run)
        cnt_ff <= baud_reload_value;
      else if (pre_wrap)
      begin
        if (cnt_ff == '0)
        begin
          cnt_ff <= baud_reload_value;
          tick16 <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff - {{(RELOAD_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// [ubt_core.sv]
// Top of the serial bit-timing core: baud ticks, transmitter, receiver, driver enable
`timescale 1ns/1ns
// Contract
// - Bit rate is clock over 16 times (2+prescale) times (reload+1).
// - Baud generator starts at enable and runs freely emitting periodic ticks.
// - Transmission starts only at the next bit tick after a request.
// - Generator count state is not visible outside the core.
// - Start detected on the clock that first sees a falling receive edge, without waiting for an oversample tick.
// - Each bit is sampled near the centre of its cell.
// - Last bit sample must precede sender frame end; 8N1 tolerates 5.26 percent.
// - Driver enable asserted while a request is pending or transmitting, released otherwise.
module ubt_core
#(
  parameter int RELOAD_W = ubt_pkg::RELOAD_W,
  parameter int DATA_W   = ubt_pkg::DATA_W
)
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                unit_enable,
  input  wire logic                baud_prescale_select,
  input  wire logic [RELOAD_W-1:0] baud_reload_value,
  input  wire logic                tx_request,
  input  wire logic [DATA_W-1:0]   tx_data,
  output logic                     tx_busy_ff,
  output logic                     serial_tx_pin_ff,
  output logic                     line_driver_enable_ff,
  input  wire logic                serial_rx_pin,
  output logic [DATA_W-1:0]        rx_data_ff,
  output logic                     rx_valid_ff,
  output logic                     rx_frame_error_ff
);
  import ubt_pkg::*;

  localparam int FRAME_BITS = DATA_W + 2;

  logic                  tick16;
  logic [3:0]            tx_sub_ff;
  logic                  bit_tick;
  logic                  tx_pend_ff;
  logic [DATA_W-1:0]     tx_data_ff;
  logic [FRAME_BITS-1:0] tx_shift_ff;
  logic [3:0]            tx_cnt_ff;
  ubt_rx_state_t         rx_state_ff;
  logic                  rx_prev_ff;
  logic [3:0]            rx_sub_ff;
  logic [3:0]            rx_cnt_ff;
  logic [DATA_W-1:0]     rx_shift_ff;

  // Baud generator; count state is kept inside it
  ubt_baud_gen #(.RELOAD_W(RELOAD_W)) u_baud
  (
    .clk                  (clk),
    .resetn               (resetn),
    .run                  (unit_enable),
    .baud_prescale_select (baud_prescale_select),
    .baud_reload_value    (baud_reload_value),
    .tick16               (tick16)
  );

  // Free-running bit tick every sixteen oversample ticks
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tx_sub_ff <= 4'h0;
    else if (!unit_enable)
      tx_sub_ff <= 4'h0;
    else if (tick16)
      tx_sub_ff <= tx_sub_ff + 4'h1;
  end

  assign bit_tick = tick16 && (tx_sub_ff == LAST_TICK);

  // Request capture until the next bit tick
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_pend_ff <= 1'b0;
      tx_data_ff <= '0;
    end
    else if (!unit_enable)
      tx_pend_ff <= 1'b0;
    else if (tx_pend_ff && bit_tick)
      tx_pend_ff <= 1'b0;
    else if (tx_request && !tx_pend_ff && !tx_busy_ff)
    begin
      tx_pend_ff <= 1'b1;
      tx_data_ff <= tx_data;
    end
  end

  // Transmit shifter: start bit, data LSB first, stop bit
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_busy_ff       <= 1'b0;
      tx_shift_ff      <= '1;
      tx_cnt_ff        <= 4'h0;
      serial_tx_pin_ff <= 1'b1;
    end
    else if (!unit_enable)
    begin
      tx_busy_ff       <= 1'b0;
      serial_tx_pin_ff <= 1'b1;
    end
    else if (bit_tick)
    begin
      if (tx_busy_ff)
      begin
        serial_tx_pin_ff <= tx_shift_ff[0];
        tx_shift_ff      <= {1'b1, tx_shift_ff[FRAME_BITS-1:1]};
        if (tx_cnt_ff == 4'h0)
        begin
          tx_busy_ff       <= 1'b0;
          serial_tx_pin_ff <= 1'b1;
        end
        else
          tx_cnt_ff <= tx_cnt_ff - 4'h1;
      end
      else if (tx_pend_ff)
      begin
        tx_busy_ff       <= 1'b1;
        serial_tx_pin_ff <= 1'b0;
        tx_shift_ff      <= {1'b1, 1'b1, tx_data_ff};
        tx_cnt_ff        <= 4'(DATA_W + 1);
      end
    end
  end

  // Driver enable follows the pending request and the transmit frame
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      line_driver_enable_ff <= 1'b0;
    else
      line_driver_enable_ff <= unit_enable && (tx_busy_ff || tx_pend_ff);
  end

  // Previous receive level for falling edge detection
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rx_prev_ff <= 1'b1;
    else
      rx_prev_ff <= serial_rx_pin;
  end

  // Receiver state machine: start edge on any clock, then oversample ticks
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_state_ff       <= UBT_RX_IDLE;
      rx_sub_ff         <= 4'h0;
      rx_cnt_ff         <= 4'h0;
      rx_shift_ff       <= '0;
      rx_data_ff        <= '0;
      rx_valid_ff       <= 1'b0;
      rx_frame_error_ff <= 1'b0;
    end
    else
    begin
      rx_valid_ff <= 1'b0;
      if (!unit_enable)
        rx_state_ff <= UBT_RX_IDLE;
      else
      begin
        unique case (rx_state_ff)
          UBT_RX_IDLE:
          begin
            if (rx_prev_ff && !serial_rx_pin)
            begin
              rx_state_ff <= UBT_RX_START;
              rx_sub_ff   <= 4'h0;
            end
          end
          UBT_RX_START:
          begin
            if (tick16)
            begin
              rx_sub_ff <= rx_sub_ff + 4'h1;
              if (rx_sub_ff == MID_TICK)
              begin
                if (serial_rx_pin)
                  rx_state_ff <= UBT_RX_IDLE;
                else
                begin
                  rx_state_ff <= UBT_RX_DATA;
                  rx_cnt_ff   <= 4'h0;
                end
              end
            end
          end
          UBT_RX_DATA:
          begin
            if (tick16)
            begin
              rx_sub_ff <= rx_sub_ff + 4'h1;
              if (rx_sub_ff == MID_TICK)
              begin
                rx_shift_ff <= {serial_rx_pin, rx_shift_ff[DATA_W-1:1]};
                rx_cnt_ff   <= rx_cnt_ff + 4'h1;
                if (rx_cnt_ff == 4'(DATA_W - 1))
                  rx_state_ff <= UBT_RX_STOP;
              end
            end
          end
          UBT_RX_STOP:
          begin
            if (tick16)
            begin
              rx_sub_ff <= rx_sub_ff + 4'h1;
              if (rx_sub_ff == MID_TICK)
              begin
                rx_data_ff        <= rx_shift_ff;
                rx_valid_ff       <= 1'b1;
                rx_frame_error_ff <= !serial_rx_pin;
                rx_state_ff       <= UBT_RX_IDLE;
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// [ubt_core_sva.sv]
// Port checker for the serial bit-timing core
`timescale 1ns/1ns
module ubt_core_sva
#(
  parameter int RELOAD_W = 13,
  parameter int DATA_W   = 8
)
(
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                unit_enable,
  input wire logic                baud_prescale_select,
  input wire logic [RELOAD_W-1:0] baud_reload_value,
  input wire logic                tx_busy_ff,
  input wire logic                serial_tx_pin_ff,
  input wire logic                line_driver_enable_ff,
  input wire logic [DATA_W-1:0]   rx_data_ff,
  input wire logic                rx_valid_ff,
  input wire logic                rx_frame_error_ff
);
  int unsigned busy_cnt_ff;
  int unsigned frame_len;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  assign frame_len = 160 * (2 + int'(baud_prescale_select)) * (int'(baud_reload_value) + 1);
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      busy_cnt_ff <= 0;
    else
      busy_cnt_ff <= tx_busy_ff ? busy_cnt_ff + 1 : 0;
  start_low_a: assert property ($rose(tx_busy_ff) |-> !serial_tx_pin_ff && unit_enable)
    else $error("frame start not low");
  idle_high_a: assert property (!tx_busy_ff |-> serial_tx_pin_ff)
    else $error("line not idle high");
  drv_cover_a: assert property (tx_busy_ff |-> line_driver_enable_ff)
    else $error("driver off in frame");
  drv_release_a: assert property ($fell(tx_busy_ff) |=> !line_driver_enable_ff)
    else $error("driver not released");
  frame_len_a: assert property ($fell(tx_busy_ff) |-> busy_cnt_ff == frame_len)
    else $error("frame length off");
  rx_pulse_a: assert property (rx_valid_ff |=> !rx_valid_ff)
    else $error("valid longer than one cycle");
  rx_hold_a: assert property (!$stable(rx_data_ff) |-> rx_valid_ff)
    else $error("data changed without valid");
  err_hold_a: assert property (!$stable(rx_frame_error_ff) |-> rx_valid_ff)
    else $error("error changed without valid");
  cover property ($fell(tx_busy_ff));
  cover property (rx_valid_ff && !rx_frame_error_ff);
  cover property (rx_valid_ff && rx_frame_error_ff);
endmodule
bind ubt_core ubt_core_sva #(.RELOAD_W(RELOAD_W), .DATA_W(DATA_W)) u_ubt_core_sva
(
  .clk                   (clk),
  .resetn                (resetn),
  .unit_enable           (unit_enable),
  .baud_prescale_select  (baud_prescale_select),
  .baud_reload_value     (baud_reload_value),
  .tx_busy_ff            (tx_busy_ff),
  .serial_tx_pin_ff      (serial_tx_pin_ff),
  .line_driver_enable_ff (line_driver_enable_ff),
  .rx_data_ff            (rx_data_ff),
  .rx_valid_ff           (rx_valid_ff),
  .rx_frame_error_ff     (rx_frame_error_ff)
);

// [ubt_pkg.sv]
// Package with widths, constants and enumerations for the serial bit-timing core
package ubt_pkg;
  localparam int RELOAD_W      = 13;
  localparam int DATA_W        = 8;
  localparam int OVERSAMPLE    = 16;
  localparam int PRESCALE_BASE = 2;
  localparam logic [3:0] MID_TICK  = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [1:0] PRE_MAX0  = 2'h1;
  localparam logic [1:0] PRE_MAX1  = 2'h2;

  typedef enum logic [1:0]
  {
    UBT_RX_IDLE  = 2'b00,
    UBT_RX_START = 2'b01,
    UBT_RX_DATA  = 2'b10,
    UBT_RX_STOP  = 2'b11
  } ubt_rx_state_t;
endpackage

// [ubt_remote.sv]
// Remote serial node: sends frames on the receive line, collects frames from the line
`timescale 1ns/1ns
module ubt_remote
(
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'h1;
  task automatic drive(input logic v, input int n);
    line_out = v;
    repeat (n) @(negedge clk);
  endtask
  // Start, eight bits LSB first, stop; n cycles per bit sets the sender rate
  task automatic send(input logic [7:0] d, input logic stop, input int n);
    @(negedge clk);
    drive(1'h0, n);
    for (int i = 0; i < 8; i++)
      drive(d[i], n);
    drive(stop, n);
    line_out = 1'h1;
  endtask
  // Samples ten cells at their centres
  task automatic collect(input int n, output logic [9:0] f);
    @(negedge line_in);
    repeat (n / 2) @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      f[i] = line_in;
      repeat (n) @(posedge clk);
    end
  endtask
endmodule
